// ---- rtl/drive_status_params.svh ----
// register offsets, bit positions and scaling constants of the status bank
`ifndef DRIVE_STATUS_PARAMS_SVH
`define DRIVE_STATUS_PARAMS_SVH
`define OFS_DRIVE_STATUS   4'h0
`define OFS_SCALED_SPEED   4'h4
`define OFS_EXT_STATUS     4'h8
`define OFS_CONTROL        4'hc
`define DSW_REMOTE_BIT     12
`define DSW_UNDERVOLT_BIT  13
`define DSW_FAULT_BIT      15
`define ESW_DCL_EXT_BIT    2
`define ESW_ENERGY_BIT     3
`define ESW_FREQ_RED_BIT   4
`define ESW_DECEL_BIT      6
`define ESW_ACCEL_BIT      7
`define ESW_FROZEN_BIT     8
`define ESW_SETPOINT_BIT   9
`define ESW_DCL_REG_BIT    10
`define ESW_50HZ_BIT       11
`define ESW_RIDE_BIT       12
`define ESW_FLYING_BIT     13
`define ESW_DC_BRAKE_BIT   14
`define ESW_PWM_BIT        15
`define ESW_RESERVED_MASK  16'h0023
`define ESW_LIVE_MASK      16'hf7dc
`define CTL_HOLD_BIT       0
`define CTL_BUSY_BIT       8
`define CTL_RATED_ZERO_BIT 9
`define SPD_FRAC_ZERO      13'h0000
`define SPD_NUM_W          29
`define SPD_STEPS          5'h1d
`define SPD_LAST_STEP      5'h01
`define SPD_POS_MAX        16'h7fff
`define SPD_NEG_MIN        16'h8000
`define SPD_RATED_CODE     16'h2000
`define WORD_RESET         16'h0000
`define BUS_ZERO           32'h0000_0000
`endif

// ---- rtl/drive_status_pkg.sv ----
// shared types and address decode of the drive status bank
`include "drive_status_params.svh"
package drive_status_pkg;
   typedef enum logic [1:0]
   {
      div_idle = 2'b00,
      div_run  = 2'b01,
      div_done = 2'b10
   } div_state_t;

   typedef enum logic [2:0]
   {
      sel_drive = 3'b000,
      sel_speed = 3'b001,
      sel_ext   = 3'b010,
      sel_ctrl  = 3'b011,
      sel_none  = 3'b100
   } reg_sel_t;

   // word address decode, shared by read mux and write path
   function automatic reg_sel_t decode_addr(input logic [3:0] addr);
      reg_sel_t sel;
      sel = sel_none;
      case (addr)
         `OFS_DRIVE_STATUS: sel = sel_drive;
         `OFS_SCALED_SPEED: sel = sel_speed;
         `OFS_EXT_STATUS:   sel = sel_ext;
         `OFS_CONTROL:      sel = sel_ctrl;
         default:           sel = sel_none;
      endcase
      return sel;
   endfunction
endpackage

// ---- rtl/speed_scaler.sv ----
// serial divider turning output frequency into the signed 16-bit scaled speed
`timescale 1ns/10ps
`include "drive_status_params.svh"
module speed_scaler
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic [15:0] freq,
   input  wire logic [15:0] rated,
   output logic      [15:0] scaled,
   output logic             busy,
   output logic             done,
   output logic             rated_zero
);
   drive_status_pkg::div_state_t state_ff;
   logic [`SPD_NUM_W-1:0] num_ff;
   logic [`SPD_NUM_W-1:0] quot_ff;
   logic [15:0]           rem_ff;
   logic [15:0]           div_ff;
   logic [15:0]           mag_ff;
   logic                  neg_ff;
   logic [4:0]            cnt_ff;
   logic [16:0]           rem_shift;
   logic [16:0]           rem_sub;
   logic [15:0]           mag;

   // magnitude of the signed input; -32768 maps to 16'h8000 unsigned
   assign mag       = freq[15] ? 16'(-freq) : freq;
   assign rem_shift = {rem_ff, num_ff[`SPD_NUM_W-1]};
   assign rem_sub   = rem_shift - {1'b0, div_ff};
   assign busy      = (state_ff != drive_status_pkg::div_idle);

   // restoring division of mag*8192 by rated frequency, one bit per clock
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_ff <= drive_status_pkg::div_idle;
         num_ff   <= '0;
         quot_ff  <= '0;
         rem_ff   <= '0;
         div_ff   <= '0;
         mag_ff   <= '0;
         neg_ff   <= 1'b0;
         cnt_ff   <= '0;
      end
      else
      begin
         unique case (state_ff)
            drive_status_pkg::div_idle:
               if (start)
               begin
                  num_ff   <= {mag, `SPD_FRAC_ZERO};
                  div_ff   <= rated;
                  mag_ff   <= mag;
                  neg_ff   <= freq[15];
                  rem_ff   <= '0;
                  quot_ff  <= '0;
                  cnt_ff   <= `SPD_STEPS;
                  state_ff <= drive_status_pkg::div_run;
               end
            drive_status_pkg::div_run:
            begin
               num_ff <= num_ff << 1;
               cnt_ff <= cnt_ff - 5'h01;
               if (!rem_sub[16])
               begin
                  rem_ff  <= rem_sub[15:0];
                  quot_ff <= {quot_ff[`SPD_NUM_W-2:0], 1'b1};
               end
               else
               begin
                  rem_ff  <= rem_shift[15:0];
                  quot_ff <= {quot_ff[`SPD_NUM_W-2:0], 1'b0};
               end
               if (cnt_ff == `SPD_LAST_STEP)
                  state_ff <= drive_status_pkg::div_done;
            end
            drive_status_pkg::div_done:
               state_ff <= drive_status_pkg::div_idle;
            default:
               state_ff <= drive_status_pkg::div_idle;
         endcase
      end
   end

   // sign and saturation; zero divisor gives zero rather than a full-scale lie
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         scaled     <= `WORD_RESET;
         done       <= 1'b0;
         rated_zero <= 1'b0;
      end
      else
      begin
         done <= (state_ff == drive_status_pkg::div_done);
         if (state_ff == drive_status_pkg::div_done)
         begin
            rated_zero <= (div_ff == `WORD_RESET);
            if (div_ff == `WORD_RESET)
               scaled <= `WORD_RESET;
            else if (!neg_ff)
               scaled <= (quot_ff > {13'h0000, `SPD_POS_MAX}) ? `SPD_POS_MAX
                                                              : quot_ff[15:0];
            else
               scaled <= (quot_ff > {13'h0000, `SPD_NEG_MIN}) ? `SPD_NEG_MIN
                                                              : 16'(-quot_ff[15:0]);
         end
      end
   end

   chk_zero_speed: assert property (@(posedge clock) disable iff (rst)
      done && mag_ff == `WORD_RESET |-> scaled == `WORD_RESET)
      else $error("zero speed not read as zero");
   chk_rated_code: assert property (@(posedge clock) disable iff (rst)
      done && !neg_ff && mag_ff == div_ff && div_ff != `WORD_RESET
      |-> scaled == `SPD_RATED_CODE)
      else $error("rated frequency not read as 8192");
   chk_four_times: assert property (@(posedge clock) disable iff (rst)
      done && !neg_ff && div_ff != `WORD_RESET && {2'b00, mag_ff} >= {div_ff, 2'b00}
      |-> scaled == `SPD_POS_MAX)
      else $error("four times rated not at positive limit");
   chk_sign_kept: assert property (@(posedge clock) disable iff (rst)
      done && neg_ff && div_ff != `WORD_RESET
      && {mag_ff, `SPD_FRAC_ZERO} >= {`SPD_FRAC_ZERO, div_ff} |-> scaled[15])
      else $error("negative speed lost its sign");
endmodule // speed_scaler

// ---- rtl/drive_status_word_bank.sv ----
// avalon-mm register bank of read-only inverter status words and speed readout
`timescale 1ns/10ps
`include "drive_status_params.svh"
module drive_status_word_bank
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic        remote_mode,
   input  wire logic        undervoltage,
   input  wire logic        fault_active,
   input  wire logic        dc_link_extended,
   input  wire logic        energy_saving,
   input  wire logic        freq_reduction,
   input  wire logic        decel_ramp,
   input  wire logic        accel_ramp,
   input  wire logic        ramp_frozen,
   input  wire logic        setpoint_reached,
   input  wire logic        dc_link_regulation,
   input  wire logic        ride_through,
   input  wire logic        flying_start,
   input  wire logic        dc_braking,
   input  wire logic        pwm_pulses_enabled,
   input  wire logic        defaults_load_req,
   input  wire logic        defaults_50hz,
   input  wire logic [15:0] output_freq,
   input  wire logic [15:0] rated_frequency_setting
);
   logic [15:0] drive_raw;
   logic [15:0] ext_raw;
   logic [15:0] drive_s1_ff;
   logic [15:0] drive_s2_ff;
   logic [15:0] ext_s1_ff;
   logic [15:0] ext_s2_ff;
   logic [1:0]  fac_s1_ff;
   logic [1:0]  fac_s2_ff;
   logic        load_prev_ff;
   logic        load_edge;
   logic        cfg_50hz_ff;
   logic [15:0] nxt_extended;
   logic [15:0] drive_status_ff;
   logic [15:0] extended_status_ff;
   logic [15:0] scaled_speed_ff;
   logic        hold_ff;
   logic        ack_ff;
   logic [31:0] readdata_ff;
   logic [31:0] nxt_readdata;
   logic [15:0] ctrl_word;
   logic        bus_req;
   logic        bus_take;
   logic [15:0] scaled_out;
   logic        conv_busy;
   logic        conv_done;
   logic        conv_rated_zero;
   drive_status_pkg::reg_sel_t sel;

   // place each status line at its bit; reserved positions stay zero
   always_comb
   begin
      drive_raw                      = `WORD_RESET;
      drive_raw[`DSW_REMOTE_BIT]     = remote_mode;
      drive_raw[`DSW_UNDERVOLT_BIT]  = undervoltage;
      drive_raw[`DSW_FAULT_BIT]      = fault_active;
      ext_raw                        = `WORD_RESET;
      ext_raw[`ESW_DCL_EXT_BIT]      = dc_link_extended;
      ext_raw[`ESW_ENERGY_BIT]       = energy_saving;
      ext_raw[`ESW_FREQ_RED_BIT]     = freq_reduction;
      ext_raw[`ESW_DECEL_BIT]        = decel_ramp;
      ext_raw[`ESW_ACCEL_BIT]        = accel_ramp;
      ext_raw[`ESW_FROZEN_BIT]       = ramp_frozen;
      ext_raw[`ESW_SETPOINT_BIT]     = setpoint_reached;
      ext_raw[`ESW_DCL_REG_BIT]      = dc_link_regulation;
      ext_raw[`ESW_RIDE_BIT]         = ride_through;
      ext_raw[`ESW_FLYING_BIT]       = flying_start;
      ext_raw[`ESW_DC_BRAKE_BIT]     = dc_braking;
      ext_raw[`ESW_PWM_BIT]          = pwm_pulses_enabled;
   end

   // two-stage synchronisers; status lines come from other control domains
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         drive_s1_ff <= `WORD_RESET;
         drive_s2_ff <= `WORD_RESET;
         ext_s1_ff   <= `WORD_RESET;
         ext_s2_ff   <= `WORD_RESET;
         fac_s1_ff   <= 2'h0;
         fac_s2_ff   <= 2'h0;
      end
      else
      begin
         drive_s1_ff <= drive_raw;
         drive_s2_ff <= drive_s1_ff;
         ext_s1_ff   <= ext_raw;
         ext_s2_ff   <= ext_s1_ff;
         fac_s1_ff   <= {defaults_50hz, defaults_load_req};
         fac_s2_ff   <= fac_s1_ff;
      end
   end

   // edge of the defaults-load request, taken from the settled stage only
   assign load_edge = fac_s2_ff[0] & ~load_prev_ff;

   // factory default region captured once per load, held until the next one
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         load_prev_ff <= 1'b0;
         cfg_50hz_ff  <= 1'b0;
      end
      else
      begin
         load_prev_ff <= fac_s2_ff[0];
         if (load_edge)
            cfg_50hz_ff <= fac_s2_ff[1];
      end
   end

   // insert the captured region bit into the second status word
   always_comb
   begin
      nxt_extended                = ext_s2_ff;
      nxt_extended[`ESW_50HZ_BIT] = cfg_50hz_ff;
   end

   // status words follow the lines unless software holds a coherent snapshot
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         drive_status_ff    <= `WORD_RESET;
         extended_status_ff <= `WORD_RESET;
      end
      else if (!hold_ff)
      begin
         drive_status_ff    <= drive_s2_ff;
         extended_status_ff <= nxt_extended;
      end
   end

   // conversions pause while held so the readout cannot move under software
   speed_scaler u_scaler
   (
      .clock      (clock),
      .rst        (rst),
      .start      (~hold_ff),
      .freq       (output_freq),
      .rated      (rated_frequency_setting),
      .scaled     (scaled_out),
      .busy       (conv_busy),
      .done       (conv_done),
      .rated_zero (conv_rated_zero)
   );

   // scaled speed takes each conversion that finishes while not held
   always_ff @(posedge clock)
   begin
      if (rst)
         scaled_speed_ff <= `WORD_RESET;
      else if (conv_done && !hold_ff)
         scaled_speed_ff <= scaled_out;
   end

   // one wait state per access; readdata is loaded on the same edge that drops waitrequest
   assign bus_req     = read | write;
   assign bus_take    = bus_req & ack_ff;
   assign waitrequest = bus_req & ~ack_ff;
   assign sel         = drive_status_pkg::decode_addr(address);

   always_ff @(posedge clock)
   begin
      if (rst)
         ack_ff <= 1'b0;
      else
         ack_ff <= bus_req & ~ack_ff;
   end

   // control word: hold flag plus converter state for software to poll
   always_comb
   begin
      ctrl_word                      = `WORD_RESET;
      ctrl_word[`CTL_HOLD_BIT]       = hold_ff;
      ctrl_word[`CTL_BUSY_BIT]       = conv_busy;
      ctrl_word[`CTL_RATED_ZERO_BIT] = conv_rated_zero;
   end

   // read mux; unmapped words read zero
   always_comb
   begin
      nxt_readdata = `BUS_ZERO;
      unique case (sel)
         drive_status_pkg::sel_drive: nxt_readdata = {`WORD_RESET, drive_status_ff};
         drive_status_pkg::sel_speed: nxt_readdata = {`WORD_RESET, scaled_speed_ff};
         drive_status_pkg::sel_ext:   nxt_readdata = {`WORD_RESET, extended_status_ff};
         drive_status_pkg::sel_ctrl:  nxt_readdata = {`WORD_RESET, ctrl_word};
         drive_status_pkg::sel_none:  nxt_readdata = `BUS_ZERO;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         readdata_ff <= `BUS_ZERO;
      else if (read && !ack_ff)
         readdata_ff <= nxt_readdata;
   end

   assign readdata = readdata_ff;

   // only the control word is writable; status words ignore writes
   always_ff @(posedge clock)
   begin
      if (rst)
         hold_ff <= 1'b0;
      else if (bus_take && write && byteenable[0] && sel == drive_status_pkg::sel_ctrl)
         hold_ff <= writedata[`CTL_HOLD_BIT];
   end

   chk_remote_follow: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && !$past(hold_ff)
      |-> drive_status_ff[`DSW_REMOTE_BIT] == $past(drive_s2_ff[`DSW_REMOTE_BIT]))
      else $error("remote bit does not follow mode");

   chk_fault_follow: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && !$past(hold_ff)
      |-> drive_status_ff[`DSW_FAULT_BIT] == $past(fault_active, 3))
      else $error("fault bit does not follow fault state");

   chk_reserved_zero: assert property (@(posedge clock) disable iff (rst)
      (extended_status_ff & `ESW_RESERVED_MASK) == `WORD_RESET)
      else $error("reserved status bits not zero");

   // every live bit of the second word trails its line by three edges
   localparam logic [15:0] live_mask = `ESW_LIVE_MASK;
   for (genvar i = 0; i < 16; i++)
   begin : g_ext_chk
      if (live_mask[i])
      begin : g_live
         chk_ext_follow: assert property (@(posedge clock) disable iff (rst)
            !$past(rst) && !$past(hold_ff)
            |-> extended_status_ff[i] == $past(ext_raw[i], 3))
            else $error("status bit does not follow its line");
      end
   end

   chk_region_capture: assert property (@(posedge clock) disable iff (rst)
      load_edge |=> ##1 extended_status_ff[`ESW_50HZ_BIT] == $past(fac_s2_ff[1], 2)
                    || $past(hold_ff))
      else $error("region bit not captured on defaults load");

   chk_write_ignored: assert property (@(posedge clock) disable iff (rst)
      bus_take && write && sel != drive_status_pkg::sel_ctrl |=> hold_ff == $past(hold_ff))
      else $error("write to status word changed state");

   chk_speed_update: assert property (@(posedge clock) disable iff (rst)
      conv_done && !hold_ff |=> scaled_speed_ff == $past(scaled_out))
      else $error("scaled speed not taken from converter");

   chk_one_wait: assert property (@(posedge clock) disable iff (rst)
      bus_req && !ack_ff |=> !waitrequest ##1 !ack_ff)
      else $error("bus answer not after one wait state");
endmodule // drive_status_word_bank

// ---- verif/drive_status_word_bank_bench.sv ----
// self-checking bench for the drive status word bank over avalon-mm
`timescale 1ns/10ps
`include "drive_status_params.svh"
`define BENCH_CHECK(got, exp, msg) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp); \
      end \
   end
module drive_status_word_bank_bench;
   logic        clock;
   logic        rst;
   logic [3:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [14:0] st;
   logic        defaults_load_req;
   logic        defaults_50hz;
   logic [15:0] output_freq;
   logic [15:0] rated_frequency_setting;
   logic [31:0] rd;
   int          errors;
   int          n_tests;
   // bit position of each status line; first three land in the main word
   int          bitpos [15] = '{`DSW_REMOTE_BIT, `DSW_UNDERVOLT_BIT, `DSW_FAULT_BIT,
      `ESW_DCL_EXT_BIT, `ESW_ENERGY_BIT, `ESW_FREQ_RED_BIT, `ESW_DECEL_BIT,
      `ESW_ACCEL_BIT, `ESW_FROZEN_BIT, `ESW_SETPOINT_BIT, `ESW_DCL_REG_BIT,
      `ESW_RIDE_BIT, `ESW_FLYING_BIT, `ESW_DC_BRAKE_BIT, `ESW_PWM_BIT};
   int          freqs [10] = '{0, 1000, 500, -1000, -500, 3999, 4000, 5000, -4000, -7};

   drive_status_word_bank dut
   (
      .clock                   (clock),
      .rst                     (rst),
      .address                 (address),
      .read                    (read),
      .write                   (write),
      .writedata               (writedata),
      .byteenable              (byteenable),
      .readdata                (readdata),
      .waitrequest             (waitrequest),
      .remote_mode             (st[0]),
      .undervoltage            (st[1]),
      .fault_active            (st[2]),
      .dc_link_extended        (st[3]),
      .energy_saving           (st[4]),
      .freq_reduction          (st[5]),
      .decel_ramp              (st[6]),
      .accel_ramp              (st[7]),
      .ramp_frozen             (st[8]),
      .setpoint_reached        (st[9]),
      .dc_link_regulation      (st[10]),
      .ride_through            (st[11]),
      .flying_start            (st[12]),
      .dc_braking              (st[13]),
      .pwm_pulses_enabled      (st[14]),
      .defaults_load_req       (defaults_load_req),
      .defaults_50hz           (defaults_50hz),
      .output_freq             (output_freq),
      .rated_frequency_setting (rated_frequency_setting)
   );

   // 50 mhz clock
   initial clock = 1'b0;
   always #10 clock = ~clock;

   // expected scaled speed: truncate toward zero, then saturate
   function automatic logic [15:0] exp_speed(input int f, input int r);
      int q;
      if (r == 0)
         return 16'h0000;
      q = ((f < 0) ? -f : f) * 8192 / r;
      if (f >= 0)
         return (q > 32767) ? 16'h7fff : 16'(q);
      return (q > 32768) ? 16'h8000 : 16'(-q);
   endfunction

   // waitrequest and readdata are taken at the rising edge itself, before
   // that edge's updates land; the request drops right after that edge
   task automatic wait_answer(output logic [31:0] d);
      int n;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 100);
      if (n >= 100)
      begin
         errors++;
         $display("MISMATCH at %0t: bus answer never came", $time);
         complete_run();
      end
      d = readdata;
      `BENCH_CHECK(n, 2, "one wait state")
   endtask

   task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock);
      read    <= 1'b1;
      address <= a;
      wait_answer(d);
      read    <= 1'b0;
   endtask

   task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] unused;
      @(posedge clock);
      write      <= 1'b1;
      address    <= a;
      writedata  <= d;
      byteenable <= 4'hf;
      wait_answer(unused);
      write      <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // watchdog sized well beyond the few thousand cycles the tests need
   initial
   begin
      #(20 * 40000);
      errors++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      complete_run();
   end

   // main sequence
   initial
   begin
      rst = 1'b1;
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      byteenable = 4'h0;
      st = 15'h0000;
      defaults_load_req = 1'b0;
      defaults_50hz = 1'b0;
      output_freq = 16'h0000;
      rated_frequency_setting = 16'd1000;
      errors = 0;
      n_tests = 0;
      settle(6);
      rst <= 1'b0;
      settle(80);
      // idle words and an unmapped place
      bus_read(4'h0, rd);
      `BENCH_CHECK(rd, 32'h0000_0000, "main word idle")
      bus_read(4'h4, rd);
      `BENCH_CHECK(rd, 32'h0000_0000, "zero speed")
      bus_read(4'h8, rd);
      `BENCH_CHECK(rd, 32'h0000_0000, "second word idle")
      bus_read(4'h6, rd);
      `BENCH_CHECK(rd, 32'h0000_0000, "unmapped read")
      $display("test idle done");
      // walk one status line at a time, both words checked for cross-talk
      for (int i = 0; i < 15; i++)
      begin
         @(posedge clock);
         st <= 15'(1 << i);
         settle(4);
         bus_read(4'h0, rd);
         `BENCH_CHECK(rd, (i < 3) ? 32'(1 << bitpos[i]) : 32'h0, "main bit")
         bus_read(4'h8, rd);
         `BENCH_CHECK(rd, (i >= 3) ? 32'(1 << bitpos[i]) : 32'h0, "second bit")
      end
      // all lines high: reserved bits stay clear
      @(posedge clock);
      st <= 15'h7fff;
      settle(4);
      bus_read(4'h0, rd);
      `BENCH_CHECK(rd, 32'h0000_b000, "main all set")
      bus_read(4'h8, rd);
      `BENCH_CHECK(rd, 32'h0000_f7dc, "second all set")
      $display("test status bits done");
      // writes to status words leave them untouched
      bus_write(4'h0, 32'hffff_ffff);
      bus_write(4'h4, 32'hffff_ffff);
      bus_write(4'h8, 32'hffff_ffff);
      bus_write(4'h6, 32'hffff_ffff);
      bus_read(4'h0, rd);
      `BENCH_CHECK(rd, 32'h0000_b000, "main after write")
      bus_read(4'h4, rd);
      `BENCH_CHECK(rd, 32'h0000_0000, "speed after write")
      bus_read(4'h8, rd);
      `BENCH_CHECK(rd, 32'h0000_f7dc, "second after write")
      $display("test read only done");
      // factory default flag: 50 hz then 60 hz
      for (int k = 1; k >= 0; k--)
      begin
         @(posedge clock);
         defaults_50hz <= 1'(k);
         settle(4);
         defaults_load_req <= 1'b1;
         settle(4);
         defaults_load_req <= 1'b0;
         settle(4);
         bus_read(4'h8, rd);
         `BENCH_CHECK(rd[11], 1'(k), "defaults flag")
      end
      $display("test defaults done");
      // hold freezes the words until released
      bus_write(4'hc, 32'h0000_0001);
      @(posedge clock);
      st <= 15'h0000;
      settle(4);
      bus_read(4'hc, rd);
      `BENCH_CHECK(rd[0], 1'b1, "hold set")
      `BENCH_CHECK(rd[9], 1'b0, "rated zero clear")
      bus_read(4'h0, rd);
      `BENCH_CHECK(rd, 32'h0000_b000, "frozen main")
      bus_write(4'hc, 32'h0000_0000);
      settle(4);
      bus_read(4'h0, rd);
      `BENCH_CHECK(rd, 32'h0000_0000, "released main")
      $display("test hold done");
      // speed scaling table, then a second rated frequency
      for (int r = 1000; r <= 2000; r += 1000)
      begin
         for (int i = 0; i < 10; i++)
         begin
            @(posedge clock);
            output_freq <= 16'(freqs[i]);
            rated_frequency_setting <= 16'(r);
            settle(100);
            bus_read(4'h4, rd);
            `BENCH_CHECK(rd, {16'h0000, exp_speed(freqs[i], r)}, "scaled speed")
         end
      end
      // zero rated frequency reads zero speed and raises the flag
      @(posedge clock);
      rated_frequency_setting <= 16'h0000;
      output_freq <= 16'h03e8;
      settle(100);
      bus_read(4'h4, rd);
      `BENCH_CHECK(rd, 32'h0000_0000, "zero rated speed")
      bus_read(4'hc, rd);
      `BENCH_CHECK(rd[9], 1'b1, "rated zero flag")
      $display("test speed done");
      complete_run();
   end
endmodule // drive_status_word_bank_bench
